// file: press_contact_sequence_monitor.sv
// Eccentric press contact sequence monitor: release, phase and error flags.
// Assumes contact pins are asynchronous; configuration and stop/run inputs
// come from controller logic on SYS_CLK; configuration is static during operation.
`timescale 1ns/100ps
module press_contact_sequence_monitor (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic UPPER_POSITION_CONTACT,
  input wire logic LOWER_POSITION_CONTACT,
  input wire logic ADVANCE_CONTACT,
  input wire logic RESTART_IN,
  input wire logic DRIVE_CMD,
  input wire logic RUN_MODE,
  input wire logic CFG_ADVANCE_EN,
  input wire logic CFG_RESTART_EN,
  input wire logic CFG_RESTART_LONG,
  input wire logic CFG_ERROR_FLAG_EN,
  input wire logic [4:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic IRQ,
  output logic RELEASE,
  output logic UPPER_AREA,
  output logic STARTUP_AREA,
  output logic CONTACT_ERROR,
  output logic RAMP_DOWN_ERROR,
  output logic RESTART_REQUIRED,
  output logic ERROR_FLAG
);

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [4:0] ADDR_STATUS = 5'h00;
  localparam logic [4:0] ADDR_EVENTS = 5'h04;
  localparam logic [4:0] ADDR_CLEAR = 5'h08;
  localparam logic [4:0] ADDR_ENABLE = 5'h0C;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic upper;
  logic lower;
  logic adv;
  logic rst_lvl;

  // Pins are asynchronous to SYS_CLK; first stage feeds only second
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {RESTART_IN, ADVANCE_CONTACT, LOWER_POSITION_CONTACT,
                  UPPER_POSITION_CONTACT};
      sync2_q <= sync1_q;
    end
  end

  assign upper = sync2_q[0];
  assign lower = sync2_q[1];
  assign adv = sync2_q[2] & CFG_ADVANCE_EN;
  assign rst_lvl = sync2_q[3] & CFG_RESTART_EN;

  // ----------------------------------------------------------------------
  // Edge detection and start-up capture
  // ----------------------------------------------------------------------
  logic upper_q;
  logic lower_q;
  logic adv_q;
  logic drive_q;
  logic run_q;
  logic [1:0] prime_q;
  logic primed_q;

  // Previous values; primed waits until the synchronisers and the previous
  // values hold real pin levels, so a contact high at reset is not an edge
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      upper_q <= 1'b0;
      lower_q <= 1'b0;
      adv_q <= 1'b0;
      drive_q <= 1'b0;
      run_q <= 1'b0;
      prime_q <= 2'h0;
      primed_q <= 1'b0;
    end else begin
      upper_q <= upper;
      lower_q <= lower;
      adv_q <= adv;
      drive_q <= DRIVE_CMD;
      run_q <= RUN_MODE;
      prime_q <= {prime_q[0], 1'b1};
      primed_q <= prime_q[1];
    end
  end

  logic upper_rise;
  logic upper_fall;
  logic lower_rise;
  logic lower_fall;
  logic adv_fall;
  logic drive_fall;
  logic run_start;
  logic restart_ok;

  assign upper_rise = primed_q & upper & ~upper_q;
  assign upper_fall = primed_q & ~upper & upper_q;
  assign lower_rise = primed_q & lower & ~lower_q;
  assign lower_fall = primed_q & ~lower & lower_q;
  assign adv_fall = primed_q & ~adv & adv_q;
  assign drive_fall = DRIVE_CMD & ~DRIVE_CMD | (~DRIVE_CMD & drive_q);
  assign run_start = RUN_MODE & ~run_q;

  // ----------------------------------------------------------------------
  // Restart pulse qualification
  // ----------------------------------------------------------------------
  pulse_timer u_pulse_timer (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .level(rst_lvl),
    .long_min(CFG_RESTART_LONG),
    .valid_q(restart_ok)
  );

  logic clear_err;
  // Restart clears only if enabled; stop/run always clears
  assign clear_err = (restart_ok & CFG_RESTART_EN) | run_start;

  // ----------------------------------------------------------------------
  // Contact sequence checks
  // ----------------------------------------------------------------------
  logic seq_bad;
  // Each upper and lower contact edge must occur in its documented phase relation
  assign seq_bad = (upper_rise & ~lower) |
                   (upper_fall & lower) |
                   (lower_rise & upper) |
                   (lower_fall & ~upper);

  // Drive history while parked at the upper point
  logic drive_ok_q;
  logic ramp_bad;

  // Drive must stay high or complete a fall while at the upper point
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      drive_ok_q <= 1'b1;
    end else if (upper_rise) begin
      drive_ok_q <= DRIVE_CMD;
    end else if (upper & drive_fall) begin
      drive_ok_q <= 1'b1;
    end else if (upper & ~DRIVE_CMD & ~drive_q & drive_ok_q) begin
      drive_ok_q <= drive_ok_q;
    end else if (upper & ~DRIVE_CMD & drive_ok_q & ~drive_fall) begin
      drive_ok_q <= drive_ok_q;
    end
  end

  // Judged on the falling upper edge with lower low
  assign ramp_bad = upper_fall & ~lower & ~drive_ok_q;

  // ----------------------------------------------------------------------
  // Latched errors
  // ----------------------------------------------------------------------
  logic contact_err_q;
  logic ramp_err_q;
  logic restart_req_q;

  // A new error in the clearing cycle wins over the clear
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      contact_err_q <= 1'b0;
      ramp_err_q <= 1'b0;
      restart_req_q <= 1'b0;
    end else begin
      if (seq_bad) begin
        contact_err_q <= 1'b1;
      end else if (clear_err) begin
        contact_err_q <= 1'b0;
      end
      if (ramp_bad) begin
        ramp_err_q <= 1'b1;
      end else if (clear_err) begin
        ramp_err_q <= 1'b0;
      end
      if (seq_bad | ramp_bad) begin
        restart_req_q <= 1'b1;
      end else if (clear_err) begin
        restart_req_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Press phase tracking
  // ----------------------------------------------------------------------
  press_monitor_pkg::phase_t phase_q;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      phase_q <= press_monitor_pkg::PH_TOP;
    end else if (!primed_q) begin
      phase_q <= upper ? press_monitor_pkg::PH_TOP
                       : press_monitor_pkg::PH_STROKE;
    end else begin
      unique case (phase_q)
        press_monitor_pkg::PH_TOP: begin
          if (upper_fall) begin
            phase_q <= press_monitor_pkg::PH_STROKE;
          end
        end
        press_monitor_pkg::PH_STROKE: begin
          if (lower_rise) begin
            phase_q <= press_monitor_pkg::PH_STARTUP;
          end else if (upper_rise) begin
            phase_q <= press_monitor_pkg::PH_TOP;
          end
        end
        press_monitor_pkg::PH_STARTUP: begin
          if (adv_fall | upper_rise) begin
            phase_q <= press_monitor_pkg::PH_TOP;
          end else if (lower_fall) begin
            phase_q <= press_monitor_pkg::PH_STROKE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Process outputs, all registered
  // ----------------------------------------------------------------------
  logic any_err;
  assign any_err = contact_err_q | ramp_err_q;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RELEASE <= press_monitor_pkg::RELEASE_RST;
      UPPER_AREA <= 1'b0;
      STARTUP_AREA <= 1'b0;
      CONTACT_ERROR <= 1'b0;
      RAMP_DOWN_ERROR <= 1'b0;
      RESTART_REQUIRED <= 1'b0;
      ERROR_FLAG <= 1'b0;
    end else begin
      // High from start-up onward, dropped by any latched error
      RELEASE <= primed_q & ~any_err & ~seq_bad & ~ramp_bad;
      UPPER_AREA <= primed_q & (phase_q == press_monitor_pkg::PH_TOP) &
                    ~any_err;
      STARTUP_AREA <= primed_q &
                      (phase_q == press_monitor_pkg::PH_STARTUP) & ~any_err;
      CONTACT_ERROR <= contact_err_q;
      RAMP_DOWN_ERROR <= ramp_err_q;
      RESTART_REQUIRED <= restart_req_q;
      ERROR_FLAG <= CFG_ERROR_FLAG_EN & any_err;
    end
  end

  // ----------------------------------------------------------------------
  // Event status, clear and enable registers; interrupt
  // ----------------------------------------------------------------------
  logic [2:0] evt_q;
  logic [2:0] evt_en_q;
  logic [2:0] evt_set;
  logic [2:0] evt_clr;

  assign evt_set = {restart_ok & CFG_RESTART_EN, ramp_bad, seq_bad};
  assign evt_clr = (REG_WR && REG_ADDR == ADDR_CLEAR) ? REG_WDATA[2:0]
                                                       : 3'h0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      evt_q <= press_monitor_pkg::EVT_RST;
      evt_en_q <= press_monitor_pkg::EVT_RST;
    end else begin
      evt_q <= (evt_q & ~evt_clr) | evt_set;
      if (REG_WR && REG_ADDR == ADDR_ENABLE) begin
        evt_en_q <= REG_WDATA[2:0];
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |((evt_q & ~evt_clr | evt_set) &
               (REG_WR && REG_ADDR == ADDR_ENABLE ? REG_WDATA[2:0]
                                                   : evt_en_q));
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= 32'h00000000;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        ADDR_STATUS: REG_RDATA <= {26'h0000000, phase_q, RELEASE,
                                   restart_req_q, ramp_err_q, contact_err_q};
        ADDR_EVENTS: REG_RDATA <= {29'h00000000, evt_q};
        ADDR_ENABLE: REG_RDATA <= {29'h00000000, evt_en_q};
        default: REG_RDATA <= 32'h00000000;
      endcase
    end else begin
      REG_RDATA <= 32'h00000000;
    end
  end

endmodule

// file: press_contact_sequence_monitor_bench.sv
// Self-checking bench for the press contact sequence monitor.
// Assumes press_model drives the contacts; restart times stay untested.
`timescale 1ns/100ps
module press_contact_sequence_monitor_bench;
  logic sys_clk, arst_n, restart_in, run_mode, reg_wr, reg_rd;
  logic adv_en, rst_en, rst_long, flag_en;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic upper, lower, drive, advance, irq, release_o, upper_area;
  logic startup_area, contact_err, ramp_err, restart_req, error_flag;
  int mismatches = 0;
  int n_checks = 0;

  press_model press_model_inst (.clk(sys_clk), .upper(upper),
    .lower(lower), .drive(drive), .advance(advance));
  press_contact_sequence_monitor press_contact_sequence_monitor_inst (
    .SYS_CLK(sys_clk), .ARST_N(arst_n), .UPPER_POSITION_CONTACT(upper),
    .LOWER_POSITION_CONTACT(lower), .ADVANCE_CONTACT(advance),
    .RESTART_IN(restart_in), .DRIVE_CMD(drive), .RUN_MODE(run_mode),
    .CFG_ADVANCE_EN(adv_en), .CFG_RESTART_EN(rst_en),
    .CFG_RESTART_LONG(rst_long), .CFG_ERROR_FLAG_EN(flag_en),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .IRQ(irq),
    .RELEASE(release_o), .UPPER_AREA(upper_area),
    .STARTUP_AREA(startup_area), .CONTACT_ERROR(contact_err),
    .RAMP_DOWN_ERROR(ramp_err), .RESTART_REQUIRED(restart_req),
    .ERROR_FLAG(error_flag));

  // ----
  // Shared tasks
  // ----
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Move the press, then step off the edge so outputs have settled
  task automatic mv(input logic u, input logic l, input logic d,
                    input logic a);
    press_model_inst.step(u, l, d, a);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [4:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask
  // Stop then run again; the only clear while restart is disabled
  task automatic stop_run();
    @(posedge sys_clk);
    run_mode <= 1'b0;
    repeat (3) @(posedge sys_clk);
    run_mode <= 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_start();
    chk_bit(release_o, 1'b1);
    chk_bit(upper_area, 1'b1);
    chk_bit(restart_req, 1'b0);
    $display("test start done");
  endtask
  // Full stroke with drive held on, then the drive falls at the top
  task automatic t_cycle();
    mv(1'b0, 1'b0, 1'b1, 1'b1);
    chk_bit(ramp_err, 1'b0);
    chk_bit(upper_area, 1'b0);
    mv(1'b0, 1'b1, 1'b1, 1'b1);
    chk_bit(startup_area, 1'b1);
    mv(1'b1, 1'b1, 1'b1, 1'b1);
    chk_bit(upper_area, 1'b1);
    mv(1'b1, 1'b0, 1'b1, 1'b1);
    chk_bit(contact_err, 1'b0);
    chk_bit(release_o, 1'b1);
    mv(1'b1, 1'b0, 1'b0, 1'b1);
    $display("test cycle done");
  endtask
  // Advance contact ignored, then honoured; drive stays low meanwhile
  task automatic t_advance();
    mv(1'b0, 1'b0, 1'b0, 1'b1);
    chk_bit(ramp_err, 1'b0);
    mv(1'b0, 1'b1, 1'b0, 1'b1);
    mv(1'b0, 1'b1, 1'b0, 1'b0);
    chk_bit(startup_area, 1'b1);
    chk_bit(upper_area, 1'b0);
    mv(1'b0, 1'b1, 1'b0, 1'b1);
    @(posedge sys_clk);
    adv_en <= 1'b1;
    mv(1'b0, 1'b1, 1'b0, 1'b0);
    chk_bit(startup_area, 1'b0);
    chk_bit(upper_area, 1'b1);
    mv(1'b1, 1'b1, 1'b0, 1'b0);
    mv(1'b1, 1'b0, 1'b0, 1'b0);
    $display("test advance done");
  endtask
  // Drive never fell at the top: leaving it is a ramp-down fault
  task automatic t_ramp();
    mv(1'b0, 1'b0, 1'b0, 1'b0);
    chk_bit(ramp_err, 1'b1);
    chk_bit(restart_req, 1'b1);
    chk_bit(release_o, 1'b0);
    chk_bit(error_flag, 1'b1);
    rd_reg(5'h04);
    chk_bit(rd[1], 1'b1);
    @(posedge sys_clk);
    rst_en <= 1'b1;
    restart_in <= 1'b1;
    repeat (3) @(posedge sys_clk);
    restart_in <= 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    chk_bit(ramp_err, 1'b1);
    @(posedge sys_clk);
    rst_en <= 1'b0;
    stop_run();
    chk_bit(ramp_err, 1'b0);
    chk_bit(restart_req, 1'b0);
    $display("test ramp done");
  endtask
  // Upper contact rises with lower low; flag output switched off
  task automatic t_contact();
    @(posedge sys_clk);
    flag_en <= 1'b0;
    mv(1'b1, 1'b0, 1'b0, 1'b0);
    chk_bit(contact_err, 1'b1);
    chk_bit(restart_req, 1'b1);
    chk_bit(release_o, 1'b0);
    chk_bit(error_flag, 1'b0);
    wr(5'h0C, 32'h00000001);
    rd_reg(5'h0C);
    chk_word(rd, 32'h00000001);
    repeat (2) @(posedge sys_clk);
    #1;
    chk_bit(irq, 1'b1);
    rd_reg(5'h04);
    chk_bit(rd[0], 1'b1);
    wr(5'h08, 32'h00000001);
    repeat (3) @(posedge sys_clk);
    #1;
    chk_bit(irq, 1'b0);
    rd_reg(5'h14);
    chk_word(rd, 32'h00000000);
    repeat (40) @(posedge sys_clk);
    #1;
    chk_bit(contact_err, 1'b1);
    stop_run();
    chk_bit(contact_err, 1'b0);
    $display("test contact done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Whole run is about 234 cycles; this allows some seventeen times that
  initial begin
    #20000;
    mismatches++;
    end_sim();
  end
  initial begin
    {arst_n, restart_in, reg_wr, reg_rd, adv_en, rst_en, rst_long} = 7'h00;
    {run_mode, flag_en} = 2'h3;
    reg_addr = 5'h00;
    reg_wdata = 32'h00000000;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    t_start();
    t_cycle();
    t_advance();
    t_ramp();
    t_contact();
    end_sim();
  end
endmodule

// file: press_model.sv
// Partner model: press position contacts, advance contact, drive command.
// Assumes the bench calls step() once for each move of the press.
`timescale 1ns/100ps
module press_model (
  input wire logic clk,
  output logic upper,
  output logic lower,
  output logic drive,
  output logic advance
);
  // Press rests at the upper point with the drive on
  initial begin
    upper = 1'b1;
    lower = 1'b0;
    drive = 1'b1;
    advance = 1'b1;
  end
  // One move per call; the long pause clears the monitor's sync delay
  task automatic step(input logic u, input logic l, input logic d,
                      input logic a);
    @(posedge clk);
    upper <= u;
    lower <= l;
    drive <= d;
    advance <= a;
    repeat (8) @(posedge clk);
  endtask
endmodule

// file: press_monitor_chk.sv
// Checker for the press contact sequence monitor, bound to its top ports.
// Assumes contact edges arrive at least eight cycles apart.
`timescale 1ns/100ps
module press_monitor_chk (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic UPPER_POSITION_CONTACT,
  input wire logic LOWER_POSITION_CONTACT,
  input wire logic ADVANCE_CONTACT,
  input wire logic RUN_MODE,
  input wire logic CFG_ADVANCE_EN,
  input wire logic CFG_RESTART_EN,
  input wire logic CFG_ERROR_FLAG_EN,
  input wire logic RELEASE,
  input wire logic UPPER_AREA,
  input wire logic STARTUP_AREA,
  input wire logic CONTACT_ERROR,
  input wire logic RAMP_DOWN_ERROR,
  input wire logic RESTART_REQUIRED,
  input wire logic ERROR_FLAG
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  // ----
  // Helper
  // ----
  // Cycles in run state; a recent stop/run may still be clearing errors
  logic [3:0] run_cnt_q;
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      run_cnt_q <= 4'h0;
    end else if (!RUN_MODE) begin
      run_cnt_q <= 4'h0;
    end else if (run_cnt_q != 4'hF) begin
      run_cnt_q <= run_cnt_q + 4'h1;
    end
  end
  // ----
  // Properties
  // ----
  start_release_a:
    assert property ($rose(ARST_N) |-> ##[0:4] RELEASE)
    else $error("release not raised after reset");
  err_release_a:
    assert property ((CONTACT_ERROR || RAMP_DOWN_ERROR) |-> !RELEASE)
    else $error("release high beside an error");
  err_flag_a:
    assert property (CFG_ERROR_FLAG_EN && (CONTACT_ERROR || RAMP_DOWN_ERROR)
      |-> ##[0:1] ERROR_FLAG)
    else $error("error flag missing");
  err_restart_a:
    assert property ($rose(CONTACT_ERROR || RAMP_DOWN_ERROR)
      |-> ##[0:1] RESTART_REQUIRED)
    else $error("restart required missing");
  err_latch_a:
    assert property ((CONTACT_ERROR || RAMP_DOWN_ERROR) && !CFG_RESTART_EN
      && run_cnt_q == 4'hF |=> (CONTACT_ERROR || RAMP_DOWN_ERROR))
    else $error("error dropped without clear");
  startup_rise_a:
    assert property ($rose(LOWER_POSITION_CONTACT) && !UPPER_POSITION_CONTACT
      && !RESTART_REQUIRED |-> ##[1:6] STARTUP_AREA)
    else $error("startup area not raised");
  order_err_a:
    assert property ($rose(UPPER_POSITION_CONTACT) && !LOWER_POSITION_CONTACT
      |-> ##[1:6] CONTACT_ERROR)
    else $error("bad upper rise not flagged");
  adv_off_a:
    assert property (!CFG_ADVANCE_EN && $fell(ADVANCE_CONTACT) && STARTUP_AREA
      && !UPPER_POSITION_CONTACT |-> ##6 STARTUP_AREA)
    else $error("disabled advance acted");
  adv_on_a:
    assert property (CFG_ADVANCE_EN && $fell(ADVANCE_CONTACT) && STARTUP_AREA
      |-> ##[1:6] (UPPER_AREA && !STARTUP_AREA))
    else $error("advance did not end startup");
endmodule

bind press_contact_sequence_monitor press_monitor_chk press_monitor_chk_inst (
  .SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
  .UPPER_POSITION_CONTACT(UPPER_POSITION_CONTACT),
  .LOWER_POSITION_CONTACT(LOWER_POSITION_CONTACT),
  .ADVANCE_CONTACT(ADVANCE_CONTACT), .RUN_MODE(RUN_MODE),
  .CFG_ADVANCE_EN(CFG_ADVANCE_EN), .CFG_RESTART_EN(CFG_RESTART_EN),
  .CFG_ERROR_FLAG_EN(CFG_ERROR_FLAG_EN), .RELEASE(RELEASE),
  .UPPER_AREA(UPPER_AREA), .STARTUP_AREA(STARTUP_AREA),
  .CONTACT_ERROR(CONTACT_ERROR), .RAMP_DOWN_ERROR(RAMP_DOWN_ERROR),
  .RESTART_REQUIRED(RESTART_REQUIRED), .ERROR_FLAG(ERROR_FLAG));

// file: press_monitor_pkg.sv
// Constants and types for the eccentric press contact sequence monitor.
// Assumes a 200 MHz system clock; all times become cycle counts here.
package press_monitor_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned RESTART_SHORT_MS = 100;
  localparam int unsigned RESTART_LONG_MS = 350;
  localparam int unsigned RESTART_MAX_S = 30;
  // Least times round up; exact here since the rate is whole MHz
  localparam longint unsigned RESTART_SHORT_CYC =
    longint'(RESTART_SHORT_MS) * 1000 * CLK_MHZ;
  localparam longint unsigned RESTART_LONG_CYC =
    longint'(RESTART_LONG_MS) * 1000 * CLK_MHZ;
  localparam longint unsigned RESTART_MAX_CYC =
    longint'(RESTART_MAX_S) * 1000000 * CLK_MHZ;
  localparam int unsigned CNT_W = 33;

  // ----------------------------------------------------------------------
  // Reset values and status layout
  // ----------------------------------------------------------------------
  localparam logic RELEASE_RST = 1'b0;
  localparam int unsigned EVT_CONTACT = 0;
  localparam int unsigned EVT_RAMP = 1;
  localparam int unsigned EVT_RESTART = 2;
  localparam int unsigned EVT_W = 3;
  localparam logic [2:0] EVT_RST = 3'h0;

  // Press cycle phase
  typedef enum logic [1:0] {
    PH_TOP,
    PH_STROKE,
    PH_STARTUP
  } phase_t;

endpackage

// file: pulse_timer.sv
// Restart pulse qualifier: measures the high time of a synchronised level.
// Assumes the input is already synchronised to SYS_CLK.
`timescale 1ns/100ps
module pulse_timer #(
  parameter logic [32:0] SHORT_CYC = 33'(press_monitor_pkg::RESTART_SHORT_CYC),
  parameter logic [32:0] LONG_CYC = 33'(press_monitor_pkg::RESTART_LONG_CYC),
  parameter logic [32:0] MAX_CYC = 33'(press_monitor_pkg::RESTART_MAX_CYC)
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic level,
  input wire logic long_min,
  output logic valid_q
);
  logic [32:0] cnt_q;
  logic level_q;
  logic [32:0] min_cyc;

  assign min_cyc = long_min ? LONG_CYC : SHORT_CYC;

  // ----------------------------------------------------------------------
  // High time counter, saturates just past the maximum
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      level_q <= 1'b0;
    end else begin
      level_q <= level;
      if (!level) begin
        cnt_q <= '0;
      end else if (cnt_q <= MAX_CYC) begin
        cnt_q <= cnt_q + 33'h000000001;
      end
    end
  end

  // Pulse on the falling edge when the high time sat inside the window
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= level_q && !level && cnt_q >= min_cyc &&
                 cnt_q <= MAX_CYC;
    end
  end
endmodule
